// [core/stuffing_framer.sv]
// Operation
// (R1) packed data never exceeds link rate; valid count clamped to unit size
// (R2) spare slots below link rate are filled with stuffing symbols
// (R3) stuffing symbols go on every active lane in one cycle, before skew
// (R4) unit holds data, then fill_start, then dummies, then fill_end
// (R5) fill_start and fill_end appear on all lanes in the same cycle
// (R6) a single stuffing slot carries fill_end only, no fill_start
// (R7) transfer unit length limited to 32 through 64 symbols per lane
// (R8) unit length stays fixed while one video format runs
// (R9) last unit of a line ends in blank_start, never fill framing
// (R10) blanking carries dummies except blanking id and m values
// (R11) blank_start sits at the same line position in vertical blanking
// (R12) blank_start, blanking id, video m low, audio m low, then dummies
// (R13) first pixel after blank_end opens the line's first unit
// (R14) first partial data of pixel 0 goes on lane 0
// (R15) a unit may split a pixel; the rest opens the next unit
// (R16) valid count per unit averages rate ratio times unit length
// (R17) each unit sends accumulated data while next accumulates, to line end
// (R18) receiver drops data after blank_start except the three attributes
// (R19) each lane lags its lower neighbour by two link clock cycles
// (R20) unit length counts all slots; fill_end takes the last slot
`timescale 1ns/1ps
`default_nettype none
`include "link_framer_map.svh"

module stuffing_framer #(
  parameter int MAX_LANES = 4
) (
  // system side clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // configuration, system clock domain
  input wire link_framer_pkg::cfg_s cfg_in,
  input wire logic cfg_load,
  output logic cfg_busy,
  output logic link_active,
  // link clock
  input wire logic link_symbol_clock,
  // line timing and blanking attributes, link clock domain
  input wire logic vblank_next,
  input wire logic [7:0] blanking_id,
  input wire logic [7:0] video_m_low,
  input wire logic [7:0] audio_m_low,
  output logic line_start,
  // packed pixel symbols, lane 0 in the low byte
  input wire logic [MAX_LANES*8-1:0] in_data,
  input wire logic in_valid,
  input wire logic in_last,
  output logic in_ready,
  output logic underrun,
  // skewed main link symbols
  output link_framer_pkg::lane_sym_s [MAX_LANES-1:0] lane_out
);

  // ============================================================
  // system side: configuration handshake
  link_framer_pkg::cfg_s cfg_hold;
  logic req_tog;
  logic ack_tog;
  logic ack_sys;
  logic running_sys_src;

  // config word is held steady until the link side acknowledges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_hold <= '0;
      req_tog <= 1'b0;
    end else if (cfg_load && !cfg_busy) begin
      cfg_hold <= cfg_in;
      req_tog <= ~req_tog;
    end
  end

  // a load while busy is ignored, software watches cfg_busy
  assign cfg_busy = req_tog ^ ack_sys;

  bit_sync u_ack_sync (.clk(sys_clk), .reset_n(reset_n), .d(ack_tog),
    .q(ack_sys));

  bit_sync u_run_sync (.clk(sys_clk), .reset_n(reset_n),
    .d(running_sys_src), .q(link_active));

  // ============================================================
  // link side: reset release and request crossing
  logic link_rst_n;
  logic req_link;
  logic req_seen;

  // reset asserts at once, releases two link edges later
  bit_sync u_rst_sync (.clk(link_symbol_clock), .reset_n(reset_n),
    .d(1'b1), .q(link_rst_n));

  bit_sync u_req_sync (.clk(link_symbol_clock), .reset_n(reset_n),
    .d(req_tog), .q(req_link));

  // unit length outside the legal window is pulled to the nearest end
  function automatic link_framer_pkg::cfg_s clamp_cfg(
    input link_framer_pkg::cfg_s c
  );
    link_framer_pkg::cfg_s r;
    r = c;
    if (c.tu_size < `TU_MIN) begin
      r.tu_size = `TU_MIN; // R7
    end else if (c.tu_size > `TU_MAX) begin
      r.tu_size = `TU_MAX; // R7
    end
    return r;
  endfunction

  // ============================================================
  // link side: pending and current configuration
  link_framer_pkg::cfg_s cfg_pend;
  link_framer_pkg::cfg_s cfg_cur;
  logic pend_valid;
  link_framer_pkg::run_state_e run_state;
  logic wrap;
  logic apply_cfg;

  // a new format takes hold at once when idle, otherwise only at the start of vertical blanking
  assign apply_cfg = pend_valid &&
    (run_state == link_framer_pkg::RUN_IDLE || (wrap && vblank_next)); // R8

  // capture after apply so a fresh request is never lost
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_seen <= 1'b0;
      ack_tog <= 1'b0;
      pend_valid <= 1'b0;
      cfg_pend <= '0;
    end else begin
      if (apply_cfg) begin
        pend_valid <= 1'b0;
      end
      if (req_link != req_seen) begin
        req_seen <= req_link;
        ack_tog <= ~ack_tog;
        cfg_pend <= clamp_cfg(cfg_hold);
        pend_valid <= 1'b1;
      end
    end
  end

  // current configuration and run state
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cfg_cur.tu_size <= `RST_TU_SIZE;
      cfg_cur.valid_x256 <= `RST_VALID_X256;
      cfg_cur.bs_pos <= `RST_BS_POS;
      cfg_cur.line_total <= `RST_LINE_TOTAL;
      cfg_cur.lanes <= link_framer_pkg::LANES_4;
      run_state <= link_framer_pkg::RUN_IDLE;
    end else if (apply_cfg) begin
      cfg_cur <= cfg_pend; // R8
      run_state <= link_framer_pkg::RUN_LINES;
    end
  end

  assign running_sys_src = (run_state == link_framer_pkg::RUN_LINES);

  // ============================================================
  // line position counter
  logic [11:0] line_pos;
  logic active_line;
  logic running;

  assign running = (run_state == link_framer_pkg::RUN_LINES);
  assign wrap = running && (line_pos == cfg_cur.line_total - 12'h001);
  assign line_start = running && (line_pos == 12'h000);

  // blank_start keeps its position whether the line is active or not
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      line_pos <= '0;
    end else if (!running || wrap) begin
      line_pos <= '0; // R11
    end else begin
      line_pos <= line_pos + 12'h001;
    end
  end

  // first line after a format change is treated as vertical blanking
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      active_line <= 1'b0;
    end else if (apply_cfg) begin
      active_line <= 1'b0;
    end else if (wrap) begin
      active_line <= !vblank_next;
    end
  end

  // ============================================================
  // transfer unit accounting
  logic [6:0] tu_pos;
  logic [6:0] n_valid;
  logic [`FRAC_W-1:0] residue;
  logic last_tu;
  logic [16:0] acc_sum;
  logic [8:0] nv_raw;
  logic [6:0] next_n_valid;
  logic [6:0] stuff;
  logic tu_prep;

  // fractional accumulator makes the integer counts alternate
  assign acc_sum = {9'h000, residue} + {1'b0, cfg_cur.valid_x256}; // R16
  assign nv_raw = acc_sum[16:8];
  // more valid symbols than slots would oversubscribe the link
  assign next_n_valid = (nv_raw > {2'b00, cfg_cur.tu_size}) ?
    cfg_cur.tu_size : nv_raw[6:0]; // R1
  // stuffing fills every slot the data leaves, fill_end included
  assign stuff = cfg_cur.tu_size - n_valid; // R20

  // a unit is prepared in the blank_end slot and in each unit's last slot
  assign tu_prep = running && active_line && line_pos < cfg_cur.bs_pos &&
    (line_pos == 12'h000 || tu_pos == cfg_cur.tu_size - 7'h01);

  // the next count is fixed while the current unit drains
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tu_pos <= '0;
      n_valid <= '0;
      residue <= '0;
      last_tu <= 1'b0;
    end else if (tu_prep) begin
      tu_pos <= '0; // R13
      n_valid <= next_n_valid; // R17
      residue <= acc_sum[`FRAC_W-1:0];
      // a unit that would run into blank_start becomes the last one
      last_tu <= (line_pos + {5'h00, cfg_cur.tu_size}) >= cfg_cur.bs_pos;
    end else begin
      tu_pos <= tu_pos + 7'h01;
    end
  end

  // ============================================================
  // slot decision for the current cycle
  link_framer_pkg::slot_kind_e slot;
  logic data_done;
  logic [11:0] bs_ofs;

  assign bs_ofs = line_pos - cfg_cur.bs_pos;

  always_comb begin
    slot = link_framer_pkg::SK_DUMMY;
    if (!running) begin
      slot = link_framer_pkg::SK_DUMMY;
    end else if (line_pos == cfg_cur.bs_pos) begin
      slot = link_framer_pkg::SK_BLANK_START; // R9
    end else if (line_pos > cfg_cur.bs_pos) begin
      // attributes follow blank_start, the rest of blanking is dummy
      unique case (bs_ofs)
        `OFS_BLANKING_ID: slot = link_framer_pkg::SK_BLANKING_ID; // R12
        `OFS_VIDEO_M: slot = link_framer_pkg::SK_VIDEO_M; // R12
        `OFS_AUDIO_M: slot = link_framer_pkg::SK_AUDIO_M; // R12
        default: slot = link_framer_pkg::SK_DUMMY; // R10
      endcase
    end else if (!active_line) begin
      slot = link_framer_pkg::SK_DUMMY; // R10
    end else if (line_pos == 12'h000) begin
      slot = link_framer_pkg::SK_BLANK_END;
    end else if (last_tu || tu_pos < n_valid) begin
      // the last unit is all data or padding up to blank_start
      slot = data_done ? link_framer_pkg::SK_PAD :
        link_framer_pkg::SK_DATA; // R4
    end else if (stuff > 7'h01 && tu_pos == n_valid) begin
      slot = link_framer_pkg::SK_FILL_START; // R4
    end else if (tu_pos == cfg_cur.tu_size - 7'h01) begin
      slot = link_framer_pkg::SK_FILL_END; // R6
    end else begin
      slot = link_framer_pkg::SK_DUMMY; // R2
    end
  end

  // the pixel stream simply continues, so a split pixel resumes next unit
  assign in_ready = (slot == link_framer_pkg::SK_DATA); // R15

  // end of pixel data for this line; a set beats the line-start clear
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      data_done <= 1'b0;
    end else if (in_ready && in_valid && in_last) begin
      data_done <= 1'b1;
    end else if (line_start) begin
      data_done <= 1'b0;
    end
  end

  // sticky flag: data was wanted but the source had none
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      underrun <= 1'b0;
    end else if (in_ready && !in_valid) begin
      underrun <= 1'b1;
    end else if (apply_cfg) begin
      underrun <= 1'b0;
    end
  end

  // ============================================================
  // lane symbol build, one register before the skew lines
  logic [2:0] lane_lim;

  // lane count code to driven lanes; the unused code drives all four
  assign lane_lim = (cfg_cur.lanes == link_framer_pkg::LANES_1) ? 3'h1 :
    (cfg_cur.lanes == link_framer_pkg::LANES_2) ? 3'h2 : 3'h4;

  link_framer_pkg::lane_sym_s [MAX_LANES-1:0] next_sym;
  link_framer_pkg::lane_sym_s [MAX_LANES-1:0] pre_skew;

  // every control and dummy symbol is the same on all active lanes
  always_comb begin
    for (int i = 0; i < MAX_LANES; i++) begin
      next_sym[i] = '0;
      if (i < int'(lane_lim)) begin
        unique case (slot)
          link_framer_pkg::SK_DATA:
            next_sym[i] = {1'b0, in_valid ? in_data[i*8 +: 8] :
              `CODE_DUMMY}; // R14
          link_framer_pkg::SK_PAD:
            next_sym[i] = {1'b0, `CODE_DUMMY};
          link_framer_pkg::SK_BLANK_END:
            next_sym[i] = {1'b1, `CODE_BLANK_END};
          link_framer_pkg::SK_BLANK_START:
            next_sym[i] = {1'b1, `CODE_BLANK_START};
          link_framer_pkg::SK_FILL_START:
            next_sym[i] = {1'b1, `CODE_FILL_START}; // R5
          link_framer_pkg::SK_FILL_END:
            next_sym[i] = {1'b1, `CODE_FILL_END}; // R5
          link_framer_pkg::SK_BLANKING_ID:
            next_sym[i] = {1'b0, blanking_id};
          link_framer_pkg::SK_VIDEO_M:
            next_sym[i] = {1'b0, video_m_low};
          link_framer_pkg::SK_AUDIO_M:
            next_sym[i] = {1'b0, audio_m_low};
          default:
            next_sym[i] = {1'b0, `CODE_DUMMY}; // R3
        endcase
      end
    end
  end

  // aligned stage: all lanes carry the stuffing in the same cycle
  always_ff @(posedge link_symbol_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pre_skew <= '0;
    end else begin
      pre_skew <= next_sym; // R3
    end
  end

  // ============================================================
  // inter-lane skew after stuffing and attributes are in place
  generate
    for (genvar g = 0; g < MAX_LANES; g++) begin : g_lane
      lane_skew #(
        .WIDTH(9),
        .DEPTH(`SKEW_CYCLES * g)
      ) u_skew (
        .clk(link_symbol_clock),
        .reset_n(link_rst_n),
        .d(pre_skew[g]),
        .q(lane_out[g])
      ); // R19
    end
  endgenerate

endmodule

`default_nettype wire

// [core/link_framer_map.svh]
`ifndef LINK_FRAMER_MAP_SVH
`define LINK_FRAMER_MAP_SVH

// ============================================================
// transfer unit limits, symbols per lane
`define TU_MIN 7'h20
`define TU_MAX 7'h40

// skew between neighbouring lanes, link clock cycles
`define SKEW_CYCLES 2

// control symbol codes carried with the ctrl flag set; the dummy code is carried with it clear
`define CODE_BLANK_START 8'hbc
`define CODE_BLANK_END 8'hfb
`define CODE_FILL_START 8'hfe
`define CODE_FILL_END 8'hf7
`define CODE_DUMMY 8'h00

// offsets after blank_start of the three blanking attributes
`define OFS_BLANKING_ID 12'h001
`define OFS_VIDEO_M 12'h002
`define OFS_AUDIO_M 12'h003

// fraction bits of the valid-symbols-per-unit figure
`define FRAC_W 8

// reset configuration
`define RST_TU_SIZE 7'h40
`define RST_VALID_X256 16'h4000
`define RST_BS_POS 12'h200
`define RST_LINE_TOTAL 12'h280

`endif

// [core/link_framer_pkg.sv]
package link_framer_pkg;

  // ============================================================
  // one symbol on one lane: ctrl high marks a control code
  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } lane_sym_s;

  // number of active lanes
  typedef enum logic [1:0] {
    LANES_1,
    LANES_2,
    LANES_4
  } lane_cnt_e;

  // per-format configuration, crosses as one word
  typedef struct packed {
    logic [6:0] tu_size;
    logic [15:0] valid_x256;
    logic [11:0] bs_pos;
    logic [11:0] line_total;
    lane_cnt_e lanes;
  } cfg_s;

  // what a symbol slot carries in a given cycle
  typedef enum logic [3:0] {
    SK_DUMMY,
    SK_DATA,
    SK_PAD,
    SK_BLANK_END,
    SK_BLANK_START,
    SK_FILL_START,
    SK_FILL_END,
    SK_BLANKING_ID,
    SK_VIDEO_M,
    SK_AUDIO_M
  } slot_kind_e;

  // link side run state
  typedef enum logic {
    RUN_IDLE,
    RUN_LINES
  } run_state_e;

endpackage

// [core/bit_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// two flop level synchroniser; first flop feeds only the second
module bit_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level in and synchronised level out
  input wire logic d,
  output logic q
);

  logic meta;

  // reset value is a constant, the input is caught on clocks only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// [core/lane_skew.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// fixed delay line for one lane of the main link
module lane_skew #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // symbol in and delayed symbol out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  generate
    if (DEPTH == 0) begin : g_pass
      // lane 0 already leaves a flop, so it passes straight
      assign q = d;
    end else begin : g_delay
      logic [WIDTH-1:0] stage [DEPTH];

      // shift register, zeros after reset read as dummy symbols
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          for (int k = 0; k < DEPTH; k++) begin
            stage[k] <= '0;
          end
        end else begin
          stage[0] <= d;
          for (int k = 1; k < DEPTH; k++) begin
            stage[k] <= stage[k-1];
          end
        end
      end

      assign q = stage[DEPTH-1];
    end
  endgenerate

endmodule

`default_nettype wire

// [tb/stuffing_framer_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_framer_map.svh"

// ============================================================
// link side checker, sees only the framer's ports
module stuffing_framer_monitor #(
  parameter int MAX_LANES = 4
) (
  // link clock and reset
  input wire logic link_symbol_clock,
  input wire logic reset_n,
  // source handshake, line timing and attributes
  input wire logic [MAX_LANES*8-1:0] in_data,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic line_start,
  input wire logic [7:0] blanking_id,
  input wire logic [7:0] video_m_low,
  input wire logic [7:0] audio_m_low,
  // skewed lanes
  input wire link_framer_pkg::lane_sym_s [MAX_LANES-1:0] lane_out
);
  localparam logic [8:0] sym_fs = {1'b1, `CODE_FILL_START};
  localparam logic [8:0] sym_fe = {1'b1, `CODE_FILL_END};
  localparam logic [8:0] sym_bs = {1'b1, `CODE_BLANK_START};
  localparam logic [8:0] sym_be = {1'b1, `CODE_BLANK_END};
  localparam logic [8:0] sym_dm = 9'h000;
  logic [8:0] l0;
  logic [8:0] l1;
  logic [8:0] l3;

  // lane 0 is the reference; the top lane lags it most
  assign l0 = lane_out[0];
  assign l1 = lane_out[1];
  assign l3 = lane_out[MAX_LANES-1];

  default clocking cb @(posedge link_symbol_clock);
  endclocking
  default disable iff (!reset_n);

  // ============================================================
  // stuffing framing
  property p_fs_lane1;
    l1 == sym_fs |-> $past(l0, 2) == sym_fs;
  endproperty
  a_fs_lane1: assert property (p_fs_lane1) else $error("lane 1 fill skew");
  property p_fs_lane3;
    l3 == sym_fs |-> $past(l0, 6) == sym_fs;
  endproperty
  a_fs_lane3: assert property (p_fs_lane3) else $error("lane 3 fill skew");
  property p_fill_dummy;
    l0 == sym_fs |=> (l0 == sym_dm) until (l0 == sym_fe);
  endproperty
  a_fill_dummy: assert property (p_fill_dummy) else $error("fill body");
  property p_fill_len;
    l0 == sym_fs |-> ##[1:63] l0 == sym_fe;
  endproperty
  a_fill_len: assert property (p_fill_len) else $error("fill unclosed");
  property p_underrun_dummy;
    in_ready && !in_valid |=> l0 == sym_dm;
  endproperty
  a_underrun_dummy: assert property (p_underrun_dummy) else $error("gap");

  // ============================================================
  // line framing and data placement
  property p_bs_attr;
    l0 == sym_bs |=> l0 == {1'b0, $past(blanking_id)}
      ##1 l0 == {1'b0, $past(video_m_low)}
      ##1 l0 == {1'b0, $past(audio_m_low)};
  endproperty
  a_bs_attr: assert property (p_bs_attr) else $error("attribute order");
  property p_bs_no_fill;
    l0 == sym_bs |-> !$past(l0[8]);
  endproperty
  a_bs_no_fill: assert property (p_bs_no_fill) else $error("line end");
  property p_be_start;
    l0 == sym_be |-> $past(line_start);
  endproperty
  a_be_start: assert property (p_be_start) else $error("blank_end slot");
  property p_data_lane0;
    in_ready && in_valid |=> l0 == {1'b0, $past(in_data[7:0])};
  endproperty
  a_data_lane0: assert property (p_data_lane0) else $error("lane 0 data");

  // main scenarios reached
  c_fill: cover property (l0 == sym_fs);
  c_line_end: cover property (l0 == sym_bs);
  c_fe_only: cover property (l0 == sym_fe && !$past(l0[8])
    && $past(l0) != sym_dm);
endmodule

bind stuffing_framer stuffing_framer_monitor #(.MAX_LANES(MAX_LANES))
  u_stuffing_framer_monitor (.link_symbol_clock, .reset_n, .in_data,
  .in_valid, .in_ready, .line_start, .blanking_id, .video_m_low,
  .audio_m_low, .lane_out);
`default_nettype wire

// [tb/link_sink_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_framer_map.svh"

// ============================================================
// sink side: deskews the lanes, drops stuffing, keeps attributes
module link_sink_model (
  // link clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // skewed lanes from the framer
  input wire link_framer_pkg::lane_sym_s [3:0] lane_in,
  // unstuffed data groups
  output logic rx_stb,
  output logic [31:0] rx_word,
  // per unit figures, valid with unit_stb
  output logic unit_stb,
  output logic [6:0] unit_n,
  output logic [6:0] unit_len,
  // last blanking attributes
  output logic [2:0][7:0] attr
);
  logic [5:0][35:0] h;
  logic [35:0] g;
  logic [8:0] c0;
  logic act;
  logic fill;
  logic [1:0] att;
  logic [6:0] n;
  logic [6:0] len;

  // undo the skew: lane i waits 6 - 2i cycles
  assign g = {lane_in[3], h[1][26:18], h[3][17:9], h[5][8:0]};
  assign c0 = g[8:0];

  // unstuffing; a pixel cut by a unit end just continues in the stream
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      h <= '0;
      act <= 1'b0;
      fill <= 1'b0;
      att <= 2'h0;
      n <= 7'h00;
      len <= 7'h00;
      rx_stb <= 1'b0;
      rx_word <= 32'h00000000;
      unit_stb <= 1'b0;
      unit_n <= 7'h00;
      unit_len <= 7'h00;
      attr <= '0;
    end else begin
      h <= {h[4:0], lane_in};
      rx_stb <= 1'b0;
      unit_stb <= 1'b0;
      len <= len + 7'h01;
      if (c0 == {1'b1, `CODE_BLANK_END}) begin
        act <= 1'b1;
        fill <= 1'b0;
        n <= 7'h00;
        len <= 7'h00;
      end else if (c0 == {1'b1, `CODE_FILL_START}) begin
        fill <= 1'b1;
      end else if (c0 == {1'b1, `CODE_FILL_END}) begin
        fill <= 1'b0;
        unit_stb <= 1'b1;
        unit_n <= n;
        unit_len <= len + 7'h01;
        n <= 7'h00;
        len <= 7'h00;
      end else if (c0 == {1'b1, `CODE_BLANK_START}) begin
        act <= 1'b0;
        att <= 2'h3;
      end else if (act && !fill) begin
        rx_stb <= 1'b1;
        rx_word <= {g[34:27], g[25:18], g[16:9], g[7:0]};
        n <= n + 7'h01;
      end else if (att != 2'h0) begin
        attr[2'h3 - att] <= c0[7:0];
        att <= att - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/main_link_symbol_stuffing_tu_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_framer_map.svh"

module main_link_symbol_stuffing_tu_tb_top;
  // ============================================================
  // stimulus, observed outputs and expectations
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_load = 1'b0;
  logic vblank_next = 1'b0;
  logic in_valid = 1'b0;
  logic in_last = 1'b0;
  logic took = 1'b0;
  logic [7:0] bid = 8'h00;
  logic [7:0] vm = 8'h00;
  logic [7:0] am = 8'h00;
  logic [31:0] in_data = 32'h00000000;
  link_framer_pkg::cfg_s cfg = '0;
  link_framer_pkg::lane_sym_s [3:0] lane_out;
  logic cfg_busy, link_active, line_start, in_ready, underrun;
  logic rx_stb, unit_stb, n_frac;
  logic [31:0] rx_word, word_exp;
  logic [6:0] unit_n, unit_len, tu_exp;
  logic [7:0] n_lo;
  logic [1:0] lane_sel;
  logic [31:0] exp_q [$];
  int seed = 12;
  int bad_count = 0;
  int cmp_count = 0;
  int stall = 0;
  int sent = 0;
  int pos = 0;
  int lines = 0;

  // free running clocks, 40 ns and 30 ns
  always #20 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;

  stuffing_framer #(.MAX_LANES(4)) u_stuffing_framer (.sys_clk, .reset_n,
    .cfg_in(cfg), .cfg_load, .cfg_busy, .link_active,
    .link_symbol_clock(link_clk), .vblank_next, .blanking_id(bid),
    .video_m_low(vm), .audio_m_low(am), .line_start, .in_data, .in_valid,
    .in_last, .in_ready, .underrun, .lane_out);
  link_sink_model u_link_sink_model (.clk(link_clk), .reset_n,
    .lane_in(lane_out), .rx_stb, .rx_word, .unit_stb, .unit_n, .unit_len,
    .attr());

  // ============================================================
  // checking helpers
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // inactive lanes carry zero
  function automatic logic [31:0] lane_mask(input logic [1:0] l);
    if (l == 2'h0) return 32'h000000ff;
    if (l == 2'h1) return 32'h0000ffff;
    return 32'hffffffff;
  endfunction

  task automatic wait_lines(input int num);
    int k;
    int stop;
    stop = lines + num;
    for (k = 0; k < 400 * num && lines < stop; k++) @(posedge link_clk);
    if (lines < stop) begin
      chk("line timeout", 32'h0, 32'h1);
      report_and_stop;
    end
  endtask

  // load a format, poke a refused second load, apply it in blanking
  task automatic load(input logic [6:0] t, input logic [15:0] vx,
    input logic [1:0] l, input logic [6:0] te);
    int k;
    cfg = '{t, vx, 12'h080, 12'h0a0, link_framer_pkg::lane_cnt_e'(l)};
    cfg_load = 1'b1;
    @(posedge sys_clk);
    #1;
    cfg.tu_size = 7'h21;
    @(posedge sys_clk);
    #1;
    cfg_load = 1'b0;
    cfg.tu_size = t;
    for (k = 0; k < 60 && cfg_busy !== 1'b0; k++) @(posedge sys_clk);
    if (cfg_busy !== 1'b0) begin
      chk("busy timeout", 32'h0, 32'h1);
      report_and_stop;
    end
    @(posedge link_clk);
    #1 vblank_next = 1'b1;
    wait_lines(2);
    tu_exp = te;
    n_lo = vx[15:8];
    n_frac = |vx[7:0];
    lane_sel = l;
    #1 vblank_next = 1'b0;
    wait_lines(4);
    #1;
  endtask

  // ============================================================
  // mid-cycle sampling, once every combinational output has settled
  always @(negedge link_clk) begin
    if (rx_stb) begin
      word_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'h00000000;
      chk("rx_word", rx_word, word_exp);
    end
    took = in_ready && in_valid;
    if (in_ready) begin
      word_exp = in_valid ? in_data & lane_mask(lane_sel) : 32'h00000000;
      exp_q.push_back(word_exp);
    end
    pos = line_start ? 0 : pos + 1;
    if (line_start) lines++;
    if (lane_out[0] === {1'b1, `CODE_BLANK_START}) begin
      chk("bs_pos", 32'(pos), 32'h00000081);
    end
    if (unit_stb) begin
      chk("unit_len", 32'(unit_len), 32'(tu_exp));
      chk("unit_n", 32'(unit_n >= n_lo && unit_n <= n_lo + n_frac), 32'h1);
    end
  end

  // random source and attributes; a group is held until it is taken
  always @(posedge link_clk) begin
    #1;
    bid = 8'($random(seed));
    vm = 8'($random(seed));
    am = 8'($random(seed));
    if (took) sent = in_last ? 0 : sent + 1;
    if (took || !in_valid) begin
      in_data = $random(seed);
      in_valid = int'({$random(seed)} % 100) >= stall;
    end
    in_last = (sent == 23);
  end

  // ============================================================
  // main sequence: formats with clamped sizes, every lane count
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    load(7'h20, 16'h0a00, 2'h2, 7'h20);
    chk("link_active", 32'(link_active), 32'h1);
    load(7'h10, 16'h1e00, 2'h1, 7'h20);
    load(7'h7f, 16'h3f00, 2'h0, 7'h40);
    load(7'h20, 16'h2800, 2'h2, 7'h20);
    chk("underrun", 32'(underrun), 32'h0);
    stall = 20;
    load(7'h20, 16'h0a80, 2'h2, 7'h20);
    chk("underrun", 32'(underrun), 32'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
